// ==== umff_cfg.svh ====
`ifndef UMFF_CFG_SVH
`define UMFF_CFG_SVH
`define UMFF_MAC_W 48
`define UMFF_BYTE_W 8
`define UMFF_HASH_W 6
`define UMFF_HASH_N 64
`define UMFF_WAKE_LEN 16
`define UMFF_HDR_BYTES 6
`define UMFF_BCAST 48'hffff_ffff_ffff
`define UMFF_GRP_BIT 40
`define UMFF_LLC_OFF 14
`define UMFF_LLC_CTL_OFF 16
`define UMFF_LLC_TEST 8'he3
`define UMFF_LLC_XID 8'haf
`define UMFF_LLC_PF_MASK 8'hef
`define UMFF_MGMT_MAC_RST 48'h02_00_00_00_00_02
`define UMFF_HOST_MAC_RST 48'h02_00_00_00_00_01
`define UMFF_CNT_W 11
`endif

// ==== umff_pkg.sv ====
package umff_pkg;
   typedef logic [47:0] umff_mac_t;
   typedef logic [7:0] umff_byte_t;
   typedef enum logic [1:0] {
      umff_dest_drop,
      umff_dest_host,
      umff_dest_mgmt
   } umff_dest_t;
   typedef enum logic [1:0] {
      umff_cmd_none,
      umff_cmd_host_grp,
      umff_cmd_wake_pat,
      umff_cmd_read_mac
   } umff_cmd_t;
endpackage

// ==== umff_frame_if.sv ====
interface umff_frame_if;
   logic valid;
   logic first;
   logic last;
   logic [7:0] data;
   modport src (output valid, output first, output last, output data);
   modport dst (input valid, input first, input last, input data);
endinterface

// ==== umff_hdr_cap.sv ====
`include "umff_cfg.svh"
// gathers the destination address from the first bytes of a frame
module umff_hdr_cap (
   input wire logic clk_sys,
   input wire logic rst,
   umff_frame_if.dst fr,
   output umff_pkg::umff_mac_t dest,
   output logic dest_done,
   output logic [`UMFF_CNT_W-1:0] idx
);
   import umff_pkg::*;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         idx <= '0;
      end else if (fr.valid) begin
         idx <= fr.last ? '0 : (fr.first ? `UMFF_CNT_W'(1) : idx + `UMFF_CNT_W'(1));
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dest <= '0;
      end else if (fr.valid && (fr.first || idx < `UMFF_CNT_W'(`UMFF_HDR_BYTES))) begin
         dest <= {dest[39:0], fr.data};
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dest_done <= 1'b0;
      end else begin
         dest_done <= fr.valid && !fr.first && idx == `UMFF_CNT_W'(`UMFF_HDR_BYTES - 1);
      end
   end
endmodule

// ==== umff_wake_match.sv ====
`include "umff_cfg.svh"
// compares frame bytes against a host-written wake pattern under a byte mask
module umff_wake_match (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [`UMFF_CNT_W-1:0] idx,
   input wire logic byte_vld,
   input wire logic frame_first,
   input wire logic [7:0] data,
   input wire logic [`UMFF_WAKE_LEN*8-1:0] pattern,
   input wire logic [`UMFF_WAKE_LEN-1:0] mask,
   output logic ok
);
   logic hit;
   logic [`UMFF_CNT_W-1:0] pos;
   always_comb begin
      pos = frame_first ? '0 : idx;
      hit = 1'b1;
      if (pos < `UMFF_CNT_W'(`UMFF_WAKE_LEN) && mask[pos[3:0]]) begin
         hit = (pattern[pos[3:0]*8 +: 8] == data);
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ok <= 1'b0;
      end else if (byte_vld) begin
         ok <= (frame_first ? 1'b1 : ok) & hit;
      end
   end
endmodule

// ==== umff_forwarder.sv ====
// What this block does
// (R1) hold two distinct 48-bit addresses; equal values are not refused, only flagged on addr_clash
// (R2) host-facing address matches unicast toward host
// (R3) management address selects own endpoint traffic
// (R4) frames to host-facing address go over usb
// (R5) broadcast frames always go to host
// (R6) multicast passes only if operator filter allows
// (R7) host may narrow multicast with own filter
// (R8) host cannot read or change operator filter
// (R9) wake pattern match while asleep triggers resume
// (R10) management-address frames never reach host
// (R11) host outbound data frames go to cable
// (R12) no pass-everything mode exists
// (R13) test and xid to host passed untouched
// (R14) 802.3 and dix frames carried unaltered
// (R15) no network-layer processing, transparent pass
// (R16) ethernet frames use cdc data interface
// (R17) host may read host-facing address
// (R18) anything else downstream is discarded
`include "umff_cfg.svh"
module umff_forwarder (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // downstream bytes from the cable side
   input wire logic dn_valid,
   input wire logic dn_first,
   input wire logic dn_last,
   input wire logic [7:0] dn_data,
   // bytes toward the usb data-class interface
   output logic host_valid,
   output logic host_first,
   output logic host_last,
   output logic [7:0] host_data,
   // bytes toward the management endpoint
   output logic mgmt_valid,
   output logic mgmt_first,
   output logic mgmt_last,
   output logic [7:0] mgmt_data,
   // upstream bytes from the usb data-class interface, and their copy toward the cable
   input wire logic up_valid,
   input wire logic up_first,
   input wire logic up_last,
   input wire logic up_is_data,
   input wire logic [7:0] up_data,
   output logic cab_valid,
   output logic cab_first,
   output logic cab_last,
   output logic [7:0] cab_data,
   // operator-side configuration, not reachable from the host
   input wire umff_pkg::umff_mac_t cfg_host_mac,
   input wire umff_pkg::umff_mac_t cfg_mgmt_mac,
   input wire logic cfg_load,
   input wire logic [`UMFF_HASH_N-1:0] op_grp_allow,
   // host management commands
   input wire logic cmd_valid,
   input wire umff_pkg::umff_cmd_t cmd_op,
   input wire logic [`UMFF_HASH_W-1:0] cmd_grp_idx,
   input wire logic cmd_grp_en,
   input wire logic [`UMFF_WAKE_LEN*8-1:0] cmd_pattern,
   input wire logic [`UMFF_WAKE_LEN-1:0] cmd_mask,
   input wire logic cmd_wake_en,
   output logic rsp_valid,
   output umff_pkg::umff_mac_t rsp_mac,
   // host power state and resume request
   input wire logic host_asleep,
   output logic resume_req,
   // status
   output logic addr_clash,
   output logic llc_to_host
);
   import umff_pkg::*;

   // a latency of seven bytes, one past the six address bytes, is needed to know the destination
   localparam int DLY = `UMFF_HDR_BYTES + 1;

   umff_mac_t host_mac;
   umff_mac_t mgmt_mac;
   logic [`UMFF_HASH_N-1:0] host_grp_allow;
   logic [`UMFF_WAKE_LEN*8-1:0] wake_pat;
   logic [`UMFF_WAKE_LEN-1:0] wake_mask;
   logic wake_en;
   umff_dest_t dest_sel;
   umff_dest_t next_dest_sel;
   umff_mac_t dest;
   logic dest_done;
   logic [`UMFF_CNT_W-1:0] idx;
   logic wake_ok;
   logic [DLY-1:0] d_valid;
   logic [DLY-1:0] d_first;
   logic [DLY-1:0] d_last;
   logic [7:0] d_data [DLY];
   logic [7:0] llc_dsap;
   logic [7:0] llc_ctl;
   logic [`UMFF_HASH_W-1:0] grp_hash;

   umff_frame_if dn_if ();
   assign dn_if.valid = dn_valid;
   assign dn_if.first = dn_first;
   assign dn_if.last = dn_last;
   assign dn_if.data = dn_data;

   umff_hdr_cap u_hdr (
      .clk_sys(clk_sys),
      .rst(rst),
      .fr(dn_if),
      .dest(dest),
      .dest_done(dest_done),
      .idx(idx)
   );

   umff_wake_match u_wake (
      .clk_sys(clk_sys),
      .rst(rst),
      .idx(idx),
      .byte_vld(dn_valid),
      .frame_first(dn_first),
      .data(dn_data),
      .pattern(wake_pat),
      .mask(wake_mask),
      .ok(wake_ok)
   );

   // addresses loaded from operator configuration only
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         host_mac <= `UMFF_HOST_MAC_RST; // see (R1)
         mgmt_mac <= `UMFF_MGMT_MAC_RST; // see (R1)
      end else if (cfg_load) begin
         host_mac <= cfg_host_mac;
         mgmt_mac <= cfg_mgmt_mac;
      end
   end

   // equal addresses are not refused; flag them
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         addr_clash <= 1'b0;
      end else begin
         addr_clash <= (host_mac == mgmt_mac); // see (R1)
      end
   end

   // host-owned group filter; operator filter is an input only
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         host_grp_allow <= '1;
      end else if (cmd_valid && cmd_op == umff_cmd_host_grp) begin
         host_grp_allow[cmd_grp_idx] <= cmd_grp_en; // see (R7) see (R8)
      end
   end

   // host-owned wake pattern of 16 bytes with its byte mask
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wake_pat <= '0;
         wake_mask <= '0;
         wake_en <= 1'b0;
      end else if (cmd_valid && cmd_op == umff_cmd_wake_pat) begin
         wake_pat <= cmd_pattern;
         wake_mask <= cmd_mask;
         wake_en <= cmd_wake_en; // see (R9)
      end
   end

   // address read answers; only the host-facing address is returned
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rsp_valid <= 1'b0;
         rsp_mac <= '0;
      end else begin
         rsp_valid <= cmd_valid && cmd_op == umff_cmd_read_mac; // see (R17)
         if (cmd_valid && cmd_op == umff_cmd_read_mac) begin
            rsp_mac <= host_mac; // see (R17)
         end
      end
   end

   // group hash from the low six bits of the last address byte
   assign grp_hash = dest[`UMFF_HASH_W-1:0];

   // destination decision, once the address is known
   always_comb begin
      next_dest_sel = dest_sel;
      if (dest_done) begin
         next_dest_sel = umff_dest_drop; // see (R18) see (R12)
         if (dest == mgmt_mac) begin
            next_dest_sel = umff_dest_mgmt; // see (R3) see (R10)
         end else if (dest == host_mac) begin
            next_dest_sel = umff_dest_host; // see (R2) see (R4)
         end else if (dest == `UMFF_BCAST) begin
            next_dest_sel = umff_dest_host; // see (R5)
         end else if (dest[`UMFF_GRP_BIT] && op_grp_allow[grp_hash] && host_grp_allow[grp_hash]) begin
            next_dest_sel = umff_dest_host; // see (R6) see (R7)
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dest_sel <= umff_dest_drop;
      end else begin
         dest_sel <= next_dest_sel;
      end
   end

   // delay line holding the header while the decision is made
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         d_valid <= '0;
         d_first <= '0;
         d_last <= '0;
      end else begin
         d_valid <= {d_valid[DLY-2:0], dn_valid};
         d_first <= {d_first[DLY-2:0], dn_valid & dn_first};
         d_last <= {d_last[DLY-2:0], dn_valid & dn_last};
      end
   end

   always_ff @(posedge clk_sys) begin
      d_data[0] <= dn_data;
      for (int i = 1; i < DLY; i++) begin
         d_data[i] <= d_data[i-1];
      end
   end

   // bytes leave unchanged, so any framing or payload is untouched
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         host_valid <= 1'b0;
         host_first <= 1'b0;
         host_last <= 1'b0;
         host_data <= '0;
      end else begin
         host_valid <= d_valid[DLY-1] && dest_sel == umff_dest_host; // see (R4) see (R16)
         host_first <= d_first[DLY-1];
         host_last <= d_last[DLY-1];
         host_data <= d_data[DLY-1]; // see (R14) see (R15) see (R13)
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mgmt_valid <= 1'b0;
         mgmt_first <= 1'b0;
         mgmt_last <= 1'b0;
         mgmt_data <= '0;
      end else begin
         mgmt_valid <= d_valid[DLY-1] && dest_sel == umff_dest_mgmt; // see (R3)
         mgmt_first <= d_first[DLY-1];
         mgmt_last <= d_last[DLY-1];
         mgmt_data <= d_data[DLY-1];
      end
   end

   // watch llc fields of host frames; such frames are only passed on
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         llc_dsap <= '0;
         llc_ctl <= '0;
      end else if (dn_valid) begin
         if (idx == `UMFF_CNT_W'(`UMFF_LLC_OFF)) begin
            llc_dsap <= dn_data;
         end
         if (idx == `UMFF_CNT_W'(`UMFF_LLC_CTL_OFF)) begin
            llc_ctl <= dn_data & `UMFF_LLC_PF_MASK;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         llc_to_host <= 1'b0;
      end else begin
         llc_to_host <= dn_valid && dn_last && dest_sel == umff_dest_host && dest == host_mac
                        && (llc_ctl == `UMFF_LLC_TEST || llc_ctl == `UMFF_LLC_XID); // see (R13)
      end
   end

   // resume when a matching frame ends while the host sleeps
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         resume_req <= 1'b0;
      end else begin
         resume_req <= wake_en && host_asleep && d_last[0] && wake_ok && dest_sel == umff_dest_host; // see (R9)
      end
   end

   // upstream: data-class frames go to the cable unchanged
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cab_valid <= 1'b0;
         cab_first <= 1'b0;
         cab_last <= 1'b0;
         cab_data <= '0;
      end else begin
         cab_valid <= up_valid && up_is_data; // see (R11) see (R16)
         cab_first <= up_first;
         cab_last <= up_last;
         cab_data <= up_data; // see (R14)
      end
   end
endmodule

// ==== umff_forwarder_sva.sv ====
module umff_sva_chk (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // frame streams
   input wire logic dn_valid,
   input wire logic dn_first,
   input wire logic [7:0] dn_data,
   input wire logic host_valid,
   input wire logic host_first,
   input wire logic [7:0] host_data,
   input wire logic mgmt_valid,
   input wire logic [7:0] mgmt_data,
   input wire logic up_valid,
   input wire logic up_is_data,
   input wire logic [7:0] up_data,
   input wire logic cab_valid,
   input wire logic [7:0] cab_data,
   // commands and power
   input wire logic cmd_valid,
   input wire umff_pkg::umff_cmd_t cmd_op,
   input wire logic rsp_valid,
   input wire logic host_asleep,
   input wire logic resume_req
);
   timeunit 1ns;
   timeprecision 1ps;
   import umff_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_cab; cab_valid == $past(up_valid && up_is_data); endproperty
   property p_cabd; cab_valid |-> cab_data == $past(up_data); endproperty
   property p_hv; host_valid |-> $past(dn_valid, 8); endproperty
   property p_hd; host_valid |-> host_data == $past(dn_data, 8) && host_first == $past(dn_first, 8); endproperty
   property p_md; mgmt_valid |-> mgmt_data == $past(dn_data, 8); endproperty
   property p_sep; not (host_valid && mgmt_valid); endproperty
   property p_rsp; cmd_valid && cmd_op == umff_cmd_read_mac |=> rsp_valid; endproperty
   property p_res; resume_req |-> host_asleep; endproperty
   a_cab: assert property (p_cab) else $error("upstream data byte not passed");
   a_cabd: assert property (p_cabd) else $error("upstream byte altered");
   a_hv: assert property (p_hv) else $error("host byte without downstream byte");
   a_hd: assert property (p_hd) else $error("host byte altered");
   a_md: assert property (p_md) else $error("management byte altered");
   a_sep: assert property (p_sep) else $error("byte sent to host and management");
   a_rsp: assert property (p_rsp) else $error("no address response");
   a_res: assert property (p_res) else $error("resume while host awake");
   c_host: cover property (host_valid && host_first);
   c_mgmt: cover property (mgmt_valid);
   c_res: cover property (resume_req);
endmodule
bind umff_forwarder umff_sva_chk chk (.clk_sys, .rst, .dn_valid, .dn_first, .dn_data, .host_valid, .host_first,
   .host_data, .mgmt_valid, .mgmt_data, .up_valid, .up_is_data, .up_data, .cab_valid, .cab_data, .cmd_valid,
   .cmd_op, .rsp_valid, .host_asleep, .resume_req);

// ==== umff_host_model.sv ====
module umff_host_model (
   // clock
   input wire logic clk_sys,
   // frames arriving over the data-class interface
   input wire logic host_valid,
   input wire logic host_first,
   input wire logic host_last,
   input wire umff_pkg::umff_byte_t host_data
);
   timeunit 1ns;
   timeprecision 1ps;
   import umff_pkg::*;
   umff_byte_t q[$];
   int nfr = 0;
   // takes each whole ethernet frame as it arrives
   always @(posedge clk_sys) begin
      if (host_valid) begin
         if (host_first) q = {};
         q.push_back(host_data);
         if (host_last) nfr++;
      end
   end
endmodule

// ==== test_usb_modem_frame_forwarder.sv ====
`define CHK(nm, e, a) begin n_compared++; if ((e) !== (a)) begin err_total++; \
   $display("mismatch %s exp %h got %h", nm, e, a); end end
module test_usb_modem_frame_forwarder;
   timeunit 1ns;
   timeprecision 1ps;
   import umff_pkg::*;
   logic clk_sys = 0, rst = 1, dn_valid = 0, dn_first = 0, dn_last = 0, cfg_load = 0;
   logic up_valid = 0, up_first = 0, up_last = 0, up_is_data = 0, cmd_valid = 0, cmd_grp_en = 0;
   logic cmd_wake_en = 0, host_asleep = 0;
   logic [7:0] dn_data = 8'h00, up_data = 8'h00;
   umff_mac_t cfg_host_mac = 48'h0200_0000_0001, cfg_mgmt_mac = 48'h0200_0000_0002;
   logic [63:0] op_grp_allow = 64'h0;
   umff_cmd_t cmd_op = umff_cmd_none;
   logic [5:0] cmd_grp_idx = 6'h00;
   logic [127:0] cmd_pattern = 128'h0;
   logic [15:0] cmd_mask = 16'h0;
   logic host_valid, host_first, host_last, mgmt_valid, mgmt_first, mgmt_last, cab_valid, cab_first, cab_last;
   logic rsp_valid, resume_req, addr_clash, llc_to_host;
   logic [7:0] host_data, mgmt_data, cab_data;
   umff_mac_t rsp_mac;
   int err_total = 0, n_compared = 0, mg_n = 0, cb_n = 0, rs_n = 0, lc_n = 0;
   umff_forwarder DUT (.clk_sys, .rst, .dn_valid, .dn_first, .dn_last, .dn_data, .host_valid, .host_first,
      .host_last, .host_data, .mgmt_valid, .mgmt_first, .mgmt_last, .mgmt_data, .up_valid, .up_first, .up_last,
      .up_is_data, .up_data, .cab_valid, .cab_first, .cab_last, .cab_data, .cfg_host_mac, .cfg_mgmt_mac,
      .cfg_load, .op_grp_allow, .cmd_valid, .cmd_op, .cmd_grp_idx, .cmd_grp_en, .cmd_pattern, .cmd_mask,
      .cmd_wake_en, .rsp_valid, .rsp_mac, .host_asleep, .resume_req, .addr_clash, .llc_to_host);
   umff_host_model hm (.clk_sys, .host_valid, .host_first, .host_last, .host_data);
   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      mg_n += mgmt_valid;
      cb_n += cab_valid;
      rs_n += resume_req;
      lc_n += llc_to_host;
   end
   function automatic umff_byte_t fb(umff_mac_t d, umff_byte_t c, int i);
      return i < 6 ? d[47-8*i -: 8] : i == 16 ? c : 8'(i * 3);
   endfunction
   // one 20-byte frame downstream, then the host and management tallies
   task automatic send(umff_mac_t d, umff_byte_t c, int e, int m);
      int f0, m0;
      f0 = hm.nfr;
      m0 = mg_n;
      for (int i = 0; i < 20; i++) begin
         @(negedge clk_sys);
         {dn_valid, dn_first, dn_last, dn_data} = {1'b1, i == 0, i == 19, fb(d, c, i)};
      end
      @(negedge clk_sys) dn_valid = 0;
      repeat (20) @(negedge clk_sys);
      `CHK("host_frames", e, hm.nfr - f0)
      `CHK("mgmt_bytes", m * 20, mg_n - m0)
      if (e == 1) begin
         `CHK("host_len", 20, hm.q.size())
         for (int i = 0; i < 20; i++) `CHK("host_byte", fb(d, c, i), hm.q[i])
      end
   endtask
   task automatic cmd(umff_cmd_t op);
      @(negedge clk_sys) {cmd_valid, cmd_op} = {1'b1, op};
      @(negedge clk_sys) cmd_valid = 0;
   endtask
   task automatic t_fwd();
      send(48'h0200_0000_0001, 8'h00, 1, 0);
      send(48'hffff_ffff_ffff, 8'h00, 1, 0);
      send(48'h0200_0000_0002, 8'h00, 0, 1);
      send(48'h0200_0000_0033, 8'h00, 0, 0);
   endtask
   task automatic t_mcast();
      send(48'h0100_5e00_0005, 8'h00, 0, 0);
      op_grp_allow = 64'h20;
      send(48'h0100_5e00_0005, 8'h00, 1, 0);
      {cmd_grp_idx, cmd_grp_en} = {6'h05, 1'b0};
      cmd(umff_cmd_host_grp);
      send(48'h0100_5e00_0005, 8'h00, 0, 0);
   endtask
   task automatic t_llc();
      int l0;
      for (int k = 0; k < 2; k++) begin
         l0 = lc_n;
         send(48'h0200_0000_0001, k ? 8'haf : 8'he3, 1, 0);
         `CHK("llc_pass", 1, lc_n - l0)
      end
   endtask
   task automatic t_up();
      int c0;
      c0 = cb_n;
      for (int i = 0; i < 20; i++) begin
         @(negedge clk_sys);
         {up_valid, up_first, up_last, up_is_data, up_data} = {1'b1, i % 10 == 0, i % 10 == 9, i < 10, 8'(i)};
      end
      @(negedge clk_sys) up_valid = 0;
      @(negedge clk_sys);
      `CHK("cab_bytes", 10, cb_n - c0)
   endtask
   task automatic t_mac();
      cmd(umff_cmd_read_mac);
      `CHK("rsp_valid", 1'b1, rsp_valid)
      `CHK("rsp_mac", 48'h0200_0000_0001, rsp_mac)
      @(negedge clk_sys);
      `CHK("rsp_pulse", 1'b0, rsp_valid)
      cfg_host_mac = 48'h0200_0000_0044;
      @(negedge clk_sys) cfg_load = 1;
      @(negedge clk_sys) cfg_load = 0;
      send(48'h0200_0000_0044, 8'h00, 1, 0);
      send(48'h0200_0000_0001, 8'h00, 0, 0);
      `CHK("addr_clash", 1'b0, addr_clash)
   endtask
   task automatic t_wake();
      int r0;
      for (int k = 0; k < 16; k++) cmd_pattern[8*k +: 8] = fb(48'h0200_0000_0044, 8'h00, k);
      {cmd_mask, cmd_wake_en, host_asleep} = {16'hffff, 1'b1, 1'b1};
      cmd(umff_cmd_wake_pat);
      r0 = rs_n;
      send(48'h0200_0000_0044, 8'h00, 1, 0);
      `CHK("resume", 1, rs_n - r0)
      send(48'hffff_ffff_ffff, 8'h00, 1, 0);
      `CHK("resume_miss", 1, rs_n - r0)
   endtask
   task automatic test_done();
      if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (4) @(negedge clk_sys);
      rst = 0;
      t_fwd();
      t_mcast();
      t_llc();
      t_up();
      t_mac();
      t_wake();
      test_done();
   end
   initial begin
      #200000;
      err_total++;
      test_done();
   end
endmodule
